//--- hdl/mplk_top.sv
// Notes on behaviour
// - current-sense trip blocks gates and forces all three phases off.
// - overcurrent latch clears each carrier period; drive resumes if fault gone.
// - carrier period is 252 oscillator cycles.
// - hall all-high, all-low or open forces all phase outputs off.
// - any other hall code re-enables outputs with no further action.
// - undervoltage flag holds all phase outputs off.
// - low bootstrap supply turns off that high-side output.
// - overtemperature turns off every output until the flag clears.
// - locked motor repeats drive then stop six times as long.
// - lock counter counts only while speed command is above run level.
// - matching rotation engages lock at or below forward speed limit.
// - opposing rotation engages lock at or below reverse speed limit.
// - every phase output is off during a lock stop interval.
// - command at disable level resets counter and stop; restart from zero.
// - drive interval 500 ticks, stop interval 3000 timer ticks.
// - no low-side bootstrap refresh pulses during a lock stop.
// - open lock-timer input forces stop mode with outputs off.
// - grounded lock-timer input keeps lock counter idle; driving continues.
// - matching rotation above limit: sine 180 when style low, wide 150 high.
// - below limit or opposing rotation: square 120 regardless of style.
`timescale 1ns/100ps
`default_nettype none
module mplk_top #(
	parameter int unsigned FWD_LIMIT_CYCLES = mplk_pkg::HALL_FWD_LIMIT_CYCLES,
	parameter int unsigned REV_LIMIT_CYCLES = mplk_pkg::HALL_REV_LIMIT_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire mplk_pkg::mplk_pins_type i_pins,
	input wire mplk_pkg::mplk_gates_type i_comm,
	output mplk_pkg::mplk_gates_type o_gates,
	output mplk_pkg::mplk_method_type o_drive_method,
	output logic o_lock_stop,
	input wire logic [7:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [7:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready
);
	import mplk_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisation

	mplk_pins_type pins;

	mplk_sync #(
		.WIDTH($bits(mplk_pins_type))
	) u_sync (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_async(i_pins),
		.o_sync(pins)
	);

	logic [1:0] control;
	logic out_enable;
	logic lock_enable;
	assign out_enable = control[CTRL_OUT_EN_BIT];
	assign lock_enable = control[CTRL_LOCK_EN_BIT];

	////////////////////////////////////////////////////////////////////////////
	// overcurrent latch paced by the carrier

	logic [7:0] carrier_cnt;
	logic carrier_end;
	logic oc_latch;

	assign carrier_end = (carrier_cnt == 8'(CARRIER_CYCLES - 1));

	always_ff @(posedge i_clk)
	begin
		if (i_rst || carrier_end)
			carrier_cnt <= '0;
		else
			carrier_cnt <= carrier_cnt + 8'h01;
	end

	// a trip in the clearing cycle wins, so no trip is lost
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			oc_latch <= 1'b0;
		else
			oc_latch <= pins.overcurrent | (oc_latch & ~carrier_end);
	end

	////////////////////////////////////////////////////////////////////////////
	// hall code, direction and speed

	logic [2:0] hall_code;
	logic [2:0] prev_code;
	logic hall_bad;
	logic hall_u_prev;
	logic hall_u_rise;
	logic rotation_cw;
	logic rotation_matches;
	logic [HALL_CNT_W-1:0] hall_cnt;
	logic [HALL_CNT_W-1:0] hall_period;
	logic slow_fwd;
	logic slow_rev;

	assign hall_code = {pins.hall_u, pins.hall_v, pins.hall_w};
	assign hall_bad = mplk_hall_invalid(hall_code) | pins.hall_open;
	assign hall_u_rise = pins.hall_u & ~hall_u_prev;
	assign rotation_matches = (rotation_cw == pins.direction_select);

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			prev_code <= 3'h0;
			hall_u_prev <= 1'b0;
		end
		else
		begin
			prev_code <= hall_code;
			hall_u_prev <= pins.hall_u;
		end
	end

	// direction judged on each valid step of the code
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			rotation_cw <= 1'b1;
		else if (hall_code != prev_code && !mplk_hall_invalid(hall_code)
			&& !mplk_hall_invalid(prev_code))
			rotation_cw <= (hall_code == mplk_next_cw(prev_code));
	end

	// electrical period measured between rising edges of phase u
	always_ff @(posedge i_clk)
	begin
		if (i_rst || hall_u_rise)
			hall_cnt <= '0;
		else if (hall_cnt != '1)
			hall_cnt <= hall_cnt + HALL_CNT_W'(1);
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			hall_period <= '1;
		else if (hall_u_rise)
			hall_period <= hall_cnt;
	end

	// a stalled rotor never gives an edge, so the running count also counts
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			slow_fwd <= 1'b1;
			slow_rev <= 1'b1;
		end
		else
		begin
			slow_fwd <= (hall_period >= HALL_CNT_W'(FWD_LIMIT_CYCLES))
				|| (hall_cnt >= HALL_CNT_W'(FWD_LIMIT_CYCLES));
			slow_rev <= (hall_period >= HALL_CNT_W'(REV_LIMIT_CYCLES))
				|| (hall_cnt >= HALL_CNT_W'(REV_LIMIT_CYCLES));
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// drive method

	mplk_method_type method;

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			method <= METHOD_SQUARE_120;
		else if (!rotation_matches || slow_fwd)
			method <= METHOD_SQUARE_120;
		else if (pins.style_select)
			method <= METHOD_WIDE_150;
		else
			method <= METHOD_SINE_180;
	end

	////////////////////////////////////////////////////////////////////////////
	// lock detection

	mplk_lock_state_type lock_state;
	logic [LOCK_CNT_W-1:0] lock_cnt;
	logic timer_prev;
	logic timer_tick;
	logic locked;
	logic lock_stop;

	assign timer_tick = pins.lock_timer_input & ~timer_prev;
	assign locked = rotation_matches ? slow_fwd : slow_rev;
	assign lock_stop = (lock_state == LOCK_STOP);

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			timer_prev <= 1'b0;
		else
			timer_prev <= pins.lock_timer_input;
	end

	// held but not cleared between the disable and run levels
	always_ff @(posedge i_clk)
	begin
		if (i_rst || !pins.vsp_above_disable)
		begin
			lock_state <= LOCK_IDLE;
			lock_cnt <= '0;
		end
		else if (pins.lock_timer_grounded || !lock_enable)
		begin
			lock_state <= LOCK_IDLE;
			lock_cnt <= '0;
		end
		else if (pins.vsp_above_run)
		begin
			unique case (lock_state)
				LOCK_IDLE:
				begin
					lock_state <= LOCK_DRIVE;
					lock_cnt <= '0;
				end
				LOCK_DRIVE:
				begin
					if (timer_tick)
					begin
						if (lock_cnt == LOCK_CNT_W'(LOCK_DRIVE_TICKS - 1))
						begin
							lock_cnt <= '0;
							if (locked)
								lock_state <= LOCK_STOP;
						end
						else
							lock_cnt <= lock_cnt + LOCK_CNT_W'(1);
					end
				end
				LOCK_STOP:
				begin
					if (timer_tick)
					begin
						if (lock_cnt == LOCK_CNT_W'(LOCK_STOP_TICKS - 1))
						begin
							lock_cnt <= '0;
							lock_state <= LOCK_DRIVE;
						end
						else
							lock_cnt <= lock_cnt + LOCK_CNT_W'(1);
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// output gating

	logic all_off;

	assign all_off = ~pins.vsp_above_disable | oc_latch | hall_bad
		| pins.undervoltage | pins.overtemp_trip | lock_stop
		| pins.lock_timer_open | ~out_enable;

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			o_gates <= '0;
			o_drive_method <= METHOD_SQUARE_120;
			o_lock_stop <= 1'b0;
		end
		else
		begin
			// low side refresh pulses ride on i_comm.low, so stop masks them
			o_gates.low <= all_off ? 3'h0 : i_comm.low;
			o_gates.high <= (all_off ? 3'h0 : i_comm.high)
				& ~pins.bootstrap_supply_low;
			o_drive_method <= method;
			o_lock_stop <= lock_stop | pins.lock_timer_open;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// status word

	mplk_status_type status;

	always_comb
	begin
		status.vsp_above_disable = pins.vsp_above_disable;
		status.vsp_above_run = pins.vsp_above_run;
		status.bootstrap_low = pins.bootstrap_supply_low;
		status.method = method;
		status.slow_rev = slow_rev;
		status.slow_fwd = slow_fwd;
		status.rotation_matches = rotation_matches;
		status.rotation_cw = rotation_cw;
		status.lock_drive = (lock_state == LOCK_DRIVE);
		status.lock_stop = lock_stop;
		status.timer_open = pins.lock_timer_open;
		status.overtemp = pins.overtemp_trip;
		status.undervoltage = pins.undervoltage;
		status.hall_bad = hall_bad;
		status.overcurrent_latch = oc_latch;
	end

	////////////////////////////////////////////////////////////////////////////
	// axi4-lite slave

	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;

	assign o_awready = ~aw_held & ~o_bvalid;
	assign o_wready = ~w_held & ~o_bvalid;
	assign do_write = aw_held & w_held & ~o_bvalid;

	// address and data are taken in either order, answer follows both
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
		end
		else if (i_awvalid && o_awready)
		begin
			aw_held <= 1'b1;
			aw_addr <= i_awaddr;
		end
		else if (do_write)
			aw_held <= 1'b0;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			w_held <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end
		else if (i_wvalid && o_wready)
		begin
			w_held <= 1'b1;
			w_data <= i_wdata;
			w_strb <= i_wstrb;
		end
		else if (do_write)
			w_held <= 1'b0;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			control <= CTRL_RESET;
		else if (do_write && aw_addr[7:2] == REG_CONTROL[7:2] && w_strb[0])
			control <= w_data[1:0];
	end

	// read-only registers accept writes silently; unmapped ones refuse
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			o_bvalid <= 1'b0;
			o_bresp <= RESP_OKAY;
		end
		else if (do_write)
		begin
			o_bvalid <= 1'b1;
			o_bresp <= (aw_addr[7:4] == 4'h0) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (i_bready)
			o_bvalid <= 1'b0;
	end

	assign o_arready = ~o_rvalid;

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			o_rvalid <= 1'b0;
			o_rdata <= 32'h0000_0000;
			o_rresp <= RESP_OKAY;
		end
		else if (i_arvalid && o_arready)
		begin
			o_rvalid <= 1'b1;
			o_rresp <= RESP_OKAY;
			unique case (i_araddr[7:2])
				REG_CONTROL[7:2]: o_rdata <= {30'h0, control};
				REG_STATUS[7:2]: o_rdata <= 32'(status);
				REG_HALL_PERIOD[7:2]: o_rdata <= 32'(hall_period);
				REG_LOCK_COUNT[7:2]: o_rdata <= {14'h0, lock_state, 4'h0, lock_cnt};
				default:
				begin
					o_rdata <= 32'h0000_0000;
					o_rresp <= RESP_SLVERR;
				end
			endcase
		end
		else if (i_rready)
			o_rvalid <= 1'b0;
	end

endmodule // mplk_top
`default_nettype wire

//--- hdl/mplk_pkg.sv
package mplk_pkg;

	// internal oscillator clock
	localparam int unsigned CLK_HZ = 25_000_000;
	// carrier period in oscillator cycles
	localparam int unsigned CARRIER_CYCLES = 252;
	// lock timer intervals in timer oscillator ticks
	localparam int unsigned LOCK_DRIVE_TICKS = 500;
	localparam int unsigned LOCK_STOP_TICKS = 3000;
	// hall speed limits, in hertz
	localparam int unsigned HALL_FWD_LIMIT_HZ = 1;
	localparam int unsigned HALL_REV_LIMIT_HZ = 5;
	// shortest electrical period that already counts as slow
	localparam int unsigned HALL_FWD_LIMIT_CYCLES = CLK_HZ / HALL_FWD_LIMIT_HZ;
	localparam int unsigned HALL_REV_LIMIT_CYCLES = CLK_HZ / HALL_REV_LIMIT_HZ;
	localparam int unsigned HALL_CNT_W = 26;
	localparam int unsigned LOCK_CNT_W = 12;

	// register byte offsets
	localparam logic [7:0] REG_CONTROL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_HALL_PERIOD = 8'h08;
	localparam logic [7:0] REG_LOCK_COUNT = 8'h0c;
	// control: bit0 output enable, bit1 lock detection enable
	localparam int unsigned CTRL_OUT_EN_BIT = 0;
	localparam int unsigned CTRL_LOCK_EN_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		METHOD_SQUARE_120,
		METHOD_SINE_180,
		METHOD_WIDE_150
	} mplk_method_type;

	typedef enum logic [1:0] {
		LOCK_IDLE,
		LOCK_DRIVE,
		LOCK_STOP
	} mplk_lock_state_type;

	// comparator flags and pins from outside the clock domain
	typedef struct packed {
		logic vsp_above_disable;
		logic vsp_above_run;
		logic overcurrent;
		logic undervoltage;
		logic overtemp_trip;
		logic [2:0] bootstrap_supply_low;
		logic hall_open;
		logic hall_u;
		logic hall_v;
		logic hall_w;
		logic lock_timer_input;
		logic lock_timer_open;
		logic lock_timer_grounded;
		logic direction_select;
		logic style_select;
	} mplk_pins_type;

	typedef struct packed {
		logic [2:0] high;
		logic [2:0] low;
	} mplk_gates_type;

	typedef struct packed {
		logic vsp_above_disable;
		logic vsp_above_run;
		logic [2:0] bootstrap_low;
		mplk_method_type method;
		logic slow_rev;
		logic slow_fwd;
		logic rotation_matches;
		logic rotation_cw;
		logic lock_drive;
		logic lock_stop;
		logic timer_open;
		logic overtemp;
		logic undervoltage;
		logic hall_bad;
		logic overcurrent_latch;
	} mplk_status_type;

	// successor of a hall code (u,v,w) for clockwise rotation
	function automatic logic [2:0] mplk_next_cw(input logic [2:0] code);
		unique case (code)
			3'h1: mplk_next_cw = 3'h3;
			3'h3: mplk_next_cw = 3'h2;
			3'h2: mplk_next_cw = 3'h6;
			3'h6: mplk_next_cw = 3'h4;
			3'h4: mplk_next_cw = 3'h5;
			3'h5: mplk_next_cw = 3'h1;
			default: mplk_next_cw = 3'h0;
		endcase
	endfunction

	function automatic logic mplk_hall_invalid(input logic [2:0] code);
		mplk_hall_invalid = (code == 3'h0) || (code == 3'h7);
	endfunction

endpackage

//--- hdl/mplk_sync.sv
`timescale 1ns/100ps
`default_nettype none
module mplk_sync #(
	parameter int unsigned WIDTH = 1
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end
		else
		begin
			stage1 <= i_async;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// a bit changes only once the last two stages agree
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++)
		begin : g_bit
			always_ff @(posedge i_clk)
			begin
				if (i_rst)
					o_sync[g] <= 1'b0;
				else if (stage2[g] == stage3[g])
					o_sync[g] <= stage3[g];
			end
		end
	endgenerate

endmodule // mplk_sync
`default_nettype wire

//--- sim/mplk_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module mplk_monitor (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire mplk_pkg::mplk_pins_type i_pins,
	input wire mplk_pkg::mplk_gates_type o_gates,
	input wire logic o_lock_stop
);
	import mplk_pkg::*;
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (i_rst);
	// seven cycles cover the pin synchroniser plus the output register
	oc_gate_a: assert property (i_pins.overcurrent [*7] |-> o_gates == '0)
		else $error("gates on during overcurrent");
	hall_bad_a: assert property ((i_pins.hall_open || {i_pins.hall_u, i_pins.hall_v,
		i_pins.hall_w} inside {3'h0, 3'h7}) [*7] |-> o_gates == '0)
		else $error("gates on with bad hall code");
	uv_off_a: assert property (i_pins.undervoltage [*7] |-> o_gates == '0)
		else $error("gates on during undervoltage");
	temp_off_a: assert property (i_pins.overtemp_trip [*7] |-> o_gates == '0)
		else $error("gates on during overtemperature");
	boot_high_a: assert property (i_pins.bootstrap_supply_low[2] [*7] |-> !o_gates.high[2])
		else $error("high side on with bootstrap low");
	stop_off_a: assert property (o_lock_stop && $past(o_lock_stop) |-> o_gates == '0)
		else $error("gates on in lock stop");
	timer_open_a: assert property (i_pins.lock_timer_open [*7] |-> o_lock_stop)
		else $error("no stop with open timer");
	disable_rel_a: assert property (!i_pins.vsp_above_disable [*7]
		|-> !o_lock_stop && o_gates == '0)
		else $error("stop or gates held at disable level");
	ground_idle_a: assert property ((i_pins.lock_timer_grounded && !i_pins.lock_timer_open) [*7]
		|-> !o_lock_stop)
		else $error("lock stop with grounded timer");
	cover property (o_lock_stop [*8]);
	cover property ($fell(o_lock_stop));
	cover property (i_pins.overcurrent ##1 !i_pins.overcurrent);
endmodule // mplk_monitor
////////////////////////////////////////////////////////////////
bind mplk_top mplk_monitor mplk_monitor_i (
	.i_clk(i_clk),
	.i_rst(i_rst),
	.i_pins(i_pins),
	.o_gates(o_gates),
	.o_lock_stop(o_lock_stop)
);
`default_nettype wire

//--- sim/mplk_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module mplk_host_model (
	input wire logic i_clk,
	input wire logic [7:0] i_step,
	input wire logic i_ccw,
	input wire logic i_tick_on,
	output logic [2:0] o_hall,
	output logic o_tick
);
	localparam logic [2:0] SEQ [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
	logic [7:0] cnt = 8'h0;
	logic [2:0] ph = 3'h0;
	logic [2:0] tc = 3'h0;
	assign o_hall = SEQ[ph];
	// timer stands still when off; ticks hold 4 cycles high and low
	assign o_tick = i_tick_on && tc[2];
	always @(posedge i_clk)
	begin
		tc <= i_tick_on ? tc + 3'h1 : 3'h0;
		if (i_step != 8'h0 && cnt >= i_step - 8'h1)
		begin
			cnt <= 8'h0;
			ph <= i_ccw ? (ph == 3'h0 ? 3'h5 : ph - 3'h1) : (ph == 3'h5 ? 3'h0 : ph + 3'h1);
		end
		else
			cnt <= cnt + 8'h1;
	end
endmodule // mplk_host_model
`default_nettype wire

//--- sim/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
	import mplk_pkg::*;
	// dir ccw style fast method
	localparam logic [5:0] ROWS [6] = '{6'h25, 6'h2e, 6'h28, 6'h34, 6'h1e, 6'h04};
	logic clk = 1'b0;
	logic rst = 1'b1;
	mplk_pins_type pins = '0;
	mplk_pins_type pins_in;
	mplk_gates_type comm = 6'h3f;
	mplk_gates_type gates;
	mplk_method_type meth;
	logic stop, awready, wready, bvalid, arready, rvalid, tick, ccw = 1'b0, ovr = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic tick_on = 1'b1;
	logic [7:0] awaddr = 8'h0, araddr = 8'h0, step = 8'h0a;
	logic [31:0] wdata = 32'h0, rdata;
	logic [1:0] bresp, rresp;
	logic [2:0] hall, hovr = 3'h7;
	logic [5:0] r;
	int n_errors = 0, total_checks = 0, k, n;
	always_comb
	begin
		pins_in = pins;
		{pins_in.hall_u, pins_in.hall_v, pins_in.hall_w} = ovr ? hovr : hall;
		pins_in.lock_timer_input = tick;
	end
	mplk_host_model mplk_host_model_i (.i_clk(clk), .i_step(step), .i_ccw(ccw),
		.i_tick_on(tick_on), .o_hall(hall), .o_tick(tick));
	mplk_top #(.FWD_LIMIT_CYCLES(200), .REV_LIMIT_CYCLES(40)) mplk_top_i (.i_clk(clk),
		.i_rst(rst), .i_pins(pins_in), .i_comm(comm), .o_gates(gates),
		.o_drive_method(meth), .o_lock_stop(stop), .i_awaddr(awaddr), .i_awvalid(awvalid),
		.o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wvalid),
		.o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
		.i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
		.o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready));
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_cyc(input int c);
		repeat (c) @(posedge clk);
	endtask
	// an edge passes first, so back to back calls never drive a strobe twice in a step
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic pb;
		logic [1:0] rsp;
		int m;
		pb = 1'b1;
		m = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (pb && m < 100)
		begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid)
			begin
				rsp = bresp;
				pb = 1'b0;
				bready <= 1'b0;
			end
			m++;
		end
		check(32'(rsp), 32'(er));
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic pb;
		logic [31:0] d;
		logic [1:0] rsp;
		int m;
		pb = 1'b1;
		m = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (pb && m < 100)
		begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid)
			begin
				d = rdata;
				rsp = rresp;
				pb = 1'b0;
				rready <= 1'b0;
			end
			m++;
		end
		check(d, ed);
		check(32'(rsp), 32'(er));
	endtask
	task automatic fault(input int f, input logic v);
		case (f)
			0: pins.overcurrent <= v;
			1: pins.undervoltage <= v;
			2: pins.overtemp_trip <= v;
			3: pins.hall_open <= v;
			4: pins.bootstrap_supply_low <= {v, 2'b00};
			5: ovr <= v;
			default: {ovr, hovr} <= {v, 3'h0};
		endcase
	endtask
	task automatic until_stop(input logic lvl, input int lim);
		n = 0;
		while (stop !== lvl && n < lim)
		begin
			@(posedge clk);
			n++;
		end
	endtask
	task automatic until_gates(input logic [5:0] v, input int lim);
		n = 0;
		while (gates !== v && n < lim)
		begin
			@(posedge clk);
			n++;
		end
	endtask
	task stop_test;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		forever #20 clk = ~clk;
	end
	initial
	begin
		#3400000;
		n_errors++;
		stop_test();
	end
	initial
	begin
		pins.vsp_above_disable <= 1'b1;
		pins.direction_select <= 1'b1;
		wait_cyc(12);
		check(32'({gates, meth, stop, bvalid, rvalid}), 32'h0);
		rst <= 1'b0;
		$display("end reset");
		for (k = 0; k < 6; k++)
		begin
			r = ROWS[k];
			pins.direction_select <= r[5];
			ccw <= r[4];
			pins.style_select <= r[3];
			step <= r[2] ? 8'h0a : 8'h64;
			wait_cyc(2500);
			check(32'(meth), 32'(r[1:0]));
			check(32'(gates), 32'h3f);
			check(32'(stop), 32'h0);
		end
		$display("end drive rows");
		rd(8'h00, 32'h3, RESP_OKAY);
		rd(8'h10, 32'h0, RESP_SLVERR);
		wr(8'h04, 32'hffffffff, RESP_OKAY);
		wr(8'h00, 32'h0, RESP_OKAY);
		wait_cyc(4);
		check(32'(gates), 32'h0);
		wr(8'h00, 32'h3, RESP_OKAY);
		rd(8'h00, 32'h3, RESP_OKAY);
		$display("end registers");
		for (k = 0; k < 7; k++)
		begin
			fault(k, 1'b1);
			wait_cyc(10);
			check(32'(gates), k == 4 ? 32'h1f : 32'h0);
			fault(k, 1'b0);
			wait_cyc(270);
			check(32'(gates), 32'h3f);
		end
		// releases land on carrier ends, so two of them lie one period apart
		fault(0, 1'b1);
		wait_cyc(10);
		fault(0, 1'b0);
		until_gates(6'h3f, 300);
		fault(0, 1'b1);
		wait_cyc(20);
		fault(0, 1'b0);
		until_gates(6'h3f, 300);
		check(32'(n), 32'(CARRIER_CYCLES - 20));
		$display("end faults");
		pins.direction_select <= 1'b0;
		step <= 8'h05;
		pins.vsp_above_run <= 1'b1;
		until_stop(1'b1, 4500);
		check(32'(stop), 32'h0);
		step <= 8'h0a;
		until_stop(1'b1, 9000);
		check(32'(stop), 32'h1);
		pins.vsp_above_disable <= 1'b0;
		pins.vsp_above_run <= 1'b0;
		wait_cyc(10);
		check(32'(stop), 32'h0);
		pins.vsp_above_disable <= 1'b1;
		step <= 8'h0;
		ccw <= 1'b0;
		pins.direction_select <= 1'b1;
		pins.vsp_above_run <= 1'b1;
		until_stop(1'b1, 6000);
		check(32'(n >= 3990 && n <= 4040), 32'h1);
		until_stop(1'b0, 30000);
		check(32'(n >= 23980 && n <= 24040), 32'h1);
		until_stop(1'b1, 6000);
		pins.vsp_above_disable <= 1'b0;
		pins.vsp_above_run <= 1'b0;
		wait_cyc(10);
		check(32'(stop), 32'h0);
		pins.vsp_above_disable <= 1'b1;
		wait_cyc(200);
		check(32'(stop), 32'h0);
		pins.vsp_above_run <= 1'b1;
		until_stop(1'b1, 6000);
		check(32'(n >= 3990 && n <= 4040), 32'h1);
		$display("end lock");
		pins.lock_timer_open <= 1'b1;
		wait_cyc(10);
		check(32'(stop), 32'h1);
		pins.lock_timer_open <= 1'b0;
		pins.lock_timer_grounded <= 1'b1;
		tick_on <= 1'b0;
		wait_cyc(5000);
		check(32'(stop), 32'h0);
		check(32'(gates), 32'h3f);
		$display("end timer pin");
		stop_test();
	end
endmodule // tb
`default_nettype wire
